// ==== rtl/liion_charge_state_control.sv ====
// charge state machine, current selection, events and register port
module liion_charge_state_control
	import charge_ctrl_pkg::*;
#(
	parameter longint PRE_TIMEOUT = PRE_TIMEOUT_CYC,
	parameter longint TOTAL_TIMEOUT = TOTAL_TIMEOUT_CYC,
	parameter longint RELAX_TIME = RELAX_CYC
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,

	// comparator indications and select/presence pins, asynchronous
	input wire logic inAboveLockout,
	input wire logic inAboveRestart,
	input wire logic inAboveOvp,
	input wire logic inBelowResume,
	input wire logic supplyTypeSelect,
	input wire logic currentLevelSelect,
	input wire logic batteryPresent,
	input wire logic batAbovePrecond,
	input wire logic batAtTermination,
	input wire logic batBelowRecharge,
	input wire logic currentAtEnd,
	input wire logic systemRailSag,

	// register port
	input wire logic [1:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdata,

	// charger power stage control and interrupt
	output logic chargeOn,
	output logic acMode,
	output logic usbHighLimit,
	output logic acDivideFive,
	output logic precondTenth,
	output logic constVoltage,
	output logic batteryHighZ,
	output logic sagReduce,
	output logic interruptOutLow
);

	// =====================================
	// input synchroniser
	logic [SYNC_W-1:0] syncA_r;
	logic [SYNC_W-1:0] syncB_r;
	logic [SYNC_W-1:0] syncRaw;

	assign syncRaw = {
		inAboveLockout, inAboveRestart, inAboveOvp, inBelowResume,
		supplyTypeSelect, currentLevelSelect, batteryPresent,
		batAbovePrecond, batAtTermination, batBelowRecharge,
		currentAtEnd, systemRailSag
	};

	// the first stage feeds only the second stage
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			syncA_r <= '0;
			syncB_r <= '0;
		end else begin
			syncA_r <= syncRaw;
			syncB_r <= syncA_r;
		end
	end

	logic aboveLockout;
	logic aboveRestart;
	logic aboveOvp;
	logic belowResume;
	logic supplyAc;
	logic levelHigh;
	logic batPresent;
	logic preReached;
	logic termReached;
	logic rechargeNeeded;
	logic endCurrent;
	logic railSag;

	assign {
		aboveLockout, aboveRestart, aboveOvp, belowResume,
		supplyAc, levelHigh, batPresent,
		preReached, termReached, rechargeNeeded,
		endCurrent, railSag
	} = syncB_r;

	// =====================================
	// input supply qualification
	logic uvlo_r;
	logic uvlo_nxt;
	logic ovp_r;
	logic ovp_nxt;
	logic inValid;
	logic supplyOk;

	always_comb begin
		uvlo_nxt = uvlo_r;
		if (!aboveLockout) begin
			uvlo_nxt = 1'b1;
		end else if (aboveRestart) begin
			// hysteresis keeps a drooping adapter from chattering
			uvlo_nxt = 1'b0;
		end
		ovp_nxt = ovp_r;
		if (aboveOvp) begin
			ovp_nxt = 1'b1;
		end else if (belowResume) begin
			ovp_nxt = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			uvlo_r <= 1'b1;
			ovp_r <= 1'b0;
		end else begin
			uvlo_r <= uvlo_nxt;
			ovp_r <= ovp_nxt;
		end
	end

	assign inValid = aboveLockout && !aboveOvp;
	assign supplyOk = !uvlo_r && !ovp_r && batPresent;

	// =====================================
	// control register
	logic [7:0] ctrl_r;
	logic [7:0] ctrl_nxt;

	always_comb begin
		ctrl_nxt = ctrl_r;
		if (regWr && regAddr == ADDR_CTRL) begin
			ctrl_nxt = regWdata;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ctrl_r <= CTRL_RESET;
		end else begin
			ctrl_r <= ctrl_nxt;
		end
	end

	logic manualSuspend;
	assign manualSuspend = ctrl_r[CTRL_SUSPEND];

	// =====================================
	// charge state machine
	chg_state_t state_r;
	chg_state_t state_nxt;
	logic [TMR_W-1:0] tmr_r;
	logic [TMR_W-1:0] tmr_nxt;
	logic relax_r;
	logic relax_nxt;
	logic preExpired;
	logic totExpired;
	logic relaxDone;

	assign preExpired = tmr_r >= TMR_W'(PRE_TIMEOUT);
	assign totExpired = tmr_r >= TMR_W'(TOTAL_TIMEOUT);
	assign relaxDone = tmr_r >= TMR_W'(RELAX_TIME);

	always_comb begin
		state_nxt = state_r;
		relax_nxt = relax_r;
		tmr_nxt = tmr_r + TMR_W'(1);
		if (!supplyOk || manualSuspend) begin
			state_nxt = ST_SUSP;
		end else begin
			case (state_r)
				ST_SUSP: begin
					// any cleared suspend cause starts over
					state_nxt = ST_PRE;
				end
				ST_PRE: begin
					if (preReached) begin
						state_nxt = ST_FAST;
					end else if (preExpired) begin
						state_nxt = ST_FAULT;
					end
				end
				ST_FAST: begin
					if (termReached) begin
						state_nxt = ST_TOP;
					end else if (totExpired) begin
						state_nxt = ST_EOC;
						relax_nxt = 1'b1;
					end
				end
				ST_TOP: begin
					if (endCurrent || totExpired) begin
						state_nxt = ST_EOC;
						relax_nxt = 1'b0;
					end
				end
				ST_EOC: begin
					if (relax_r && relaxDone) begin
						state_nxt = ST_PRE;
					end else if (!relax_r && rechargeNeeded) begin
						state_nxt = ST_PRE;
					end
				end
				ST_FAULT: begin
					// fault holds until a suspend cause clears it
					state_nxt = ST_FAULT;
				end
				default: begin
					state_nxt = ST_SUSP;
				end
			endcase
		end
		// the total timer spans the whole cycle; end-of-charge reuses it
		if (state_nxt != state_r &&
				(state_nxt == ST_PRE || state_nxt == ST_EOC)) begin
			tmr_nxt = '0;
		end else if (state_r == ST_SUSP || state_r == ST_FAULT) begin
			tmr_nxt = '0;
		end else if (state_r == ST_EOC && !relax_r) begin
			tmr_nxt = tmr_r;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_r <= ST_SUSP;
			tmr_r <= '0;
			relax_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			tmr_r <= tmr_nxt;
			relax_r <= relax_nxt;
		end
	end

	// =====================================
	// power stage outputs
	logic chargeOn_nxt;
	logic precondTenth_nxt;
	logic constVoltage_nxt;
	logic batteryHighZ_nxt;

	always_comb begin
		chargeOn_nxt = state_r == ST_PRE || state_r == ST_FAST ||
			state_r == ST_TOP;
		precondTenth_nxt = state_r == ST_PRE;
		constVoltage_nxt = state_r == ST_TOP;
		batteryHighZ_nxt = !chargeOn_nxt;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			chargeOn <= 1'b0;
			precondTenth <= 1'b0;
			constVoltage <= 1'b0;
			batteryHighZ <= 1'b1;
			acMode <= 1'b0;
			usbHighLimit <= 1'b0;
			acDivideFive <= 1'b0;
			sagReduce <= 1'b0;
		end else begin
			chargeOn <= chargeOn_nxt;
			precondTenth <= precondTenth_nxt;
			constVoltage <= constVoltage_nxt;
			batteryHighZ <= batteryHighZ_nxt;
			acMode <= supplyAc;
			usbHighLimit <= !supplyAc && levelHigh;
			acDivideFive <= supplyAc && !levelHigh;
			// level follows the sag comparator so current backs off only as needed
			sagReduce <= railSag;
		end
	end

	// =====================================
	// event detection and flags
	logic prevValid_r;
	logic prevEoc_r;
	logic inFlag_r;
	logic inFlag_nxt;
	logic chgFlag_r;
	logic chgFlag_nxt;
	logic inEvent;
	logic chgEvent;
	logic statusRead;
	logic inEoc;

	assign inEoc = state_r == ST_EOC;
	assign statusRead = regRd && regAddr == ADDR_STATUS;

	always_comb begin
		inEvent = ctrl_r[CTRL_IN_EVT_EN] && (
			(inValid && !prevValid_r && ctrl_r[CTRL_CONNECT_EN]) ||
			(!inValid && prevValid_r && ctrl_r[CTRL_DISCONNECT_EN]));
		chgEvent = ctrl_r[CTRL_CHG_EVT_EN] && (
			(inEoc && !prevEoc_r && ctrl_r[CTRL_ENTRY_EN]) ||
			(!inEoc && prevEoc_r && ctrl_r[CTRL_EXIT_EN]));
		// a new event beats the clear of the same cycle
		inFlag_nxt = inEvent || (inFlag_r && !statusRead);
		chgFlag_nxt = chgEvent || (chgFlag_r && !statusRead);
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			prevValid_r <= 1'b0;
			prevEoc_r <= 1'b0;
			inFlag_r <= 1'b0;
			chgFlag_r <= 1'b0;
			interruptOutLow <= 1'b1;
		end else begin
			prevValid_r <= inValid;
			prevEoc_r <= inEoc;
			inFlag_r <= inFlag_nxt;
			chgFlag_r <= chgFlag_nxt;
			interruptOutLow <= !(inFlag_nxt || chgFlag_nxt);
		end
	end

	// =====================================
	// register read
	logic [1:0] phase;
	logic [7:0] status;
	logic [7:0] regRdata_nxt;

	always_comb begin
		case (state_r)
			ST_PRE: phase = 2'h3;
			ST_FAST, ST_TOP: phase = 2'h1;
			ST_EOC: phase = 2'h2;
			default: phase = 2'h0;
		endcase
		status = 8'h00;
		status[ST_IN_FLAG] = inFlag_r;
		status[ST_IN_VALID] = inValid;
		status[ST_SUPPLY_TYPE] = supplyAc;
		status[ST_CHG_FLAG] = chgFlag_r;
		status[ST_DONE] = inEoc;
		status[ST_PHASE0] = phase[0];
		status[ST_PHASE1] = phase[1];
		regRdata_nxt = 8'h00;
		if (regRd) begin
			if (regAddr == ADDR_CTRL) begin
				regRdata_nxt = ctrl_r;
			end else if (regAddr == ADDR_STATUS) begin
				regRdata_nxt = status;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			regRdata <= 8'h00;
		end else begin
			regRdata <= regRdata_nxt;
		end
	end

endmodule

// ==== include/charge_ctrl_pkg.sv ====
// constants and types shared by the charger control logic
package charge_ctrl_pkg;

	// =====================================
	// register map
	localparam logic [1:0] ADDR_CTRL = 2'h0;
	localparam logic [1:0] ADDR_STATUS = 2'h1;

	// control register bits
	localparam int CTRL_IN_EVT_EN = 0;
	localparam int CTRL_CONNECT_EN = 1;
	localparam int CTRL_DISCONNECT_EN = 2;
	localparam int CTRL_CHG_EVT_EN = 3;
	localparam int CTRL_ENTRY_EN = 4;
	localparam int CTRL_EXIT_EN = 5;
	localparam int CTRL_SUSPEND = 6;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// status register bits
	localparam int ST_IN_FLAG = 0;
	localparam int ST_IN_VALID = 1;
	localparam int ST_SUPPLY_TYPE = 2;
	localparam int ST_CHG_FLAG = 3;
	localparam int ST_DONE = 4;
	localparam int ST_PHASE0 = 5;
	localparam int ST_PHASE1 = 6;

	// =====================================
	// timing
	localparam longint CLK_HZ = 125000000;
	localparam longint PRE_TIMEOUT_MIN = 40;
	localparam longint TOTAL_TIMEOUT_HR = 3;
	localparam longint RELAX_MS = 32;
	localparam longint PRE_TIMEOUT_CYC = PRE_TIMEOUT_MIN * 60 * CLK_HZ;
	localparam longint TOTAL_TIMEOUT_CYC = TOTAL_TIMEOUT_HR * 3600 * CLK_HZ;
	localparam longint RELAX_CYC = RELAX_MS * CLK_HZ / 1000;
	localparam int TMR_W = 42;

	// number of synchronised comparator and select/presence pin inputs
	localparam int SYNC_W = 12;

	typedef enum logic [2:0] {
		ST_SUSP,
		ST_PRE,
		ST_FAST,
		ST_TOP,
		ST_EOC,
		ST_FAULT
	} chg_state_t;

endpackage

// ==== tb/liion_charge_state_control_checker.sv ====
// port assertions for the charger control block
module liion_charge_state_control_checker
	import charge_ctrl_pkg::*;
(
	// clock and reset
	input logic sys_clk,
	input logic sys_rst,
	// pins and register port
	input logic supplyTypeSelect,
	input logic currentLevelSelect,
	input logic systemRailSag,
	input logic [1:0] regAddr,
	input logic regRd,
	// power stage and interrupt
	input logic chargeOn,
	input logic acMode,
	input logic usbHighLimit,
	input logic acDivideFive,
	input logic precondTenth,
	input logic constVoltage,
	input logic batteryHighZ,
	input logic sagReduce,
	input logic interruptOutLow
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================
	// properties
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// five samples cover two synchroniser flops and the output register
	sequence held(s);
		s [*5];
	endsequence
	chk_ac_select: assert property (held(supplyTypeSelect) |-> acMode)
		else $error("ac mode not selected");
	chk_usb_high: assert property (held(!supplyTypeSelect && currentLevelSelect) |-> usbHighLimit)
		else $error("usb high limit missing");
	chk_usb_low: assert property (held(!supplyTypeSelect && !currentLevelSelect) |-> !usbHighLimit && !acMode)
		else $error("usb low limit missing");
	chk_divide_five: assert property (held(supplyTypeSelect && !currentLevelSelect) |-> acDivideFive)
		else $error("ac divide missing");
	chk_sag_reduce: assert property (held(systemRailSag) |-> sagReduce)
		else $error("sag reduction missing");
	chk_high_z: assert property (batteryHighZ != chargeOn)
		else $error("high impedance wrong");
	chk_tenth_only: assert property (precondTenth |-> chargeOn && !constVoltage)
		else $error("tenth current outside charging");
	chk_cv_topoff: assert property (constVoltage |-> chargeOn && !precondTenth)
		else $error("constant voltage outside top-off");
	chk_irq_hold: assert property (!interruptOutLow && !regRd |=> !interruptOutLow)
		else $error("interrupt released without read");
	chk_irq_release: assert property ($rose(interruptOutLow) |-> $past(regRd) && $past(regAddr) == ADDR_STATUS)
		else $error("interrupt rose without status read");
endmodule

bind liion_charge_state_control liion_charge_state_control_checker u_checker (
	.sys_clk, .sys_rst, .supplyTypeSelect, .currentLevelSelect, .systemRailSag, .regAddr, .regRd,
	.chargeOn, .acMode, .usbHighLimit, .acDivideFive, .precondTenth, .constVoltage, .batteryHighZ,
	.sagReduce, .interruptOutLow
);

// ==== tb/battery_supply_model.sv ====
// cell and input supply as seen through the charger comparators
module battery_supply_model (
	// clock
	input wire logic sys_clk,
	// bench controls
	input wire logic [15:0] inMv,
	input wire logic [15:0] loadMv,
	input wire logic load,
	input wire logic stall,
	// charger drive
	input wire logic chargeOn,
	input wire logic constVoltage,
	// comparators
	output logic inAboveLockout,
	output logic inAboveRestart,
	output logic inAboveOvp,
	output logic inBelowResume,
	output logic batAbovePrecond,
	output logic batAtTermination,
	output logic batBelowRecharge,
	output logic currentAtEnd
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] batMv = 16'h09c4;
	logic [3:0] cvCnt = 4'h0;
	// stall freezes the cell so the safety timers can run out
	always @(posedge sys_clk) begin
		if (load)
			batMv <= loadMv;
		else if (chargeOn && !stall && batMv < 16'h1068)
			batMv <= batMv + 16'h0032;
		cvCnt <= (constVoltage && cvCnt < 4'h8) ? cvCnt + 4'h1 : (constVoltage ? cvCnt : 4'h0);
	end
	assign inAboveLockout = inMv > 16'h0dac;
	assign inAboveRestart = inMv > 16'h0fa0;
	assign inAboveOvp = inMv > 16'h19c8;
	assign inBelowResume = inMv < 16'h1770;
	assign batAbovePrecond = batMv > 16'h0bb8;
	assign batAtTermination = batMv >= 16'h1068;
	assign batBelowRecharge = batMv < 16'h0f9b;
	assign currentAtEnd = cvCnt == 4'h8;
endmodule

// ==== tb/test_liion_charge_state_control.sv ====
// self-checking bench for the charger control block
module test_liion_charge_state_control
	import charge_ctrl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0, sys_rst = 1'b1;
	logic supplyTypeSelect = 1'b0, currentLevelSelect = 1'b0;
	logic batteryPresent = 1'b1, systemRailSag = 1'b0;
	logic [1:0] regAddr = 2'h0;
	logic [7:0] regWdata = 8'h00, regRdata, seed = 8'h50;
	logic regWr = 1'b0, regRd = 1'b0, load = 1'b0, stall = 1'b0;
	logic [15:0] inMv = 16'h0000, loadMv = 16'h09c4;
	logic chargeOn, acMode, usbHighLimit, acDivideFive, precondTenth, constVoltage;
	logic batteryHighZ, sagReduce, interruptOutLow, inAboveLockout, inAboveRestart;
	logic inAboveOvp, inBelowResume, batAbovePrecond, batAtTermination, batBelowRecharge;
	logic currentAtEnd;
	int numErrors = 0, samplesChecked = 0;

	always #4 sys_clk = ~sys_clk;

	liion_charge_state_control #(.PRE_TIMEOUT(20), .TOTAL_TIMEOUT(60), .RELAX_TIME(8))
	u_liion_charge_state_control (.sys_clk, .sys_rst, .inAboveLockout, .inAboveRestart,
		.inAboveOvp, .inBelowResume, .supplyTypeSelect, .currentLevelSelect, .batteryPresent,
		.batAbovePrecond, .batAtTermination, .batBelowRecharge, .currentAtEnd, .systemRailSag,
		.regAddr, .regWdata, .regWr, .regRd, .regRdata, .chargeOn, .acMode, .usbHighLimit,
		.acDivideFive, .precondTenth, .constVoltage, .batteryHighZ, .sagReduce, .interruptOutLow);

	battery_supply_model u_battery_supply_model (.sys_clk, .inMv, .loadMv, .load, .stall,
		.chargeOn, .constVoltage, .inAboveLockout, .inAboveRestart, .inAboveOvp, .inBelowResume,
		.batAbovePrecond, .batAtTermination, .batBelowRecharge, .currentAtEnd);

	// ==========================================
	// tasks
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	// selects which power-stage output a bounded wait watches
	localparam int SIG_ON = 0;
	localparam int SIG_CV = 1;
	localparam int SIG_HIZ = 2;
	function automatic logic pick(input int w);
		if (w == SIG_ON)
			return chargeOn;
		else if (w == SIG_CV)
			return constVoltage;
		return batteryHighZ;
	endfunction
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		samplesChecked++;
		if (g !== e) begin
			numErrors++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task wr(input logic [7:0] d);
		@(posedge sys_clk);
		regWr <= 1'b1;
		regAddr <= ADDR_CTRL;
		regWdata <= d;
		@(posedge sys_clk);
		regWr <= 1'b0;
	endtask
	task rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge sys_clk);
		regRd <= 1'b0;
		#1 d = regRdata;
	endtask
	task st(input logic [7:0] m, input logic [7:0] e);
		logic [7:0] d;
		rd(ADDR_STATUS, d);
		chk("status", e, d & m);
	endtask
	task ld(input logic [15:0] v);
		@(posedge sys_clk);
		loadMv <= v;
		load <= 1'b1;
		@(posedge sys_clk);
		load <= 1'b0;
	endtask
	// a bounded wait; running out counts as a mismatch
	task automatic waitFor(input int w, input logic v, input int n);
		int i;
		for (i = 0; i < n && pick(w) !== v; i++)
			cyc(1);
		chk("wait", 8'(v), 8'(pick(w)));
	endtask
	task finishTest;
		$display("comparisons %0d mismatches %0d", samplesChecked, numErrors);
		if (numErrors == 0 && samplesChecked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ==========================================
	// scenarios
	initial begin
		logic [7:0] d;
		repeat (3) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rd(ADDR_CTRL, d);
		chk("ctrl", CTRL_RESET, d);
		st(8'h62, 8'h00);
		wr(8'h3f);
		@(posedge sys_clk) inMv <= 16'h1388;
		cyc(6);
		chk("irq", 8'h00, 8'(interruptOutLow));
		st(8'h63, 8'h63);
		st(8'h01, 8'h00);
		chk("irq", 8'h01, 8'(interruptOutLow));
		waitFor(SIG_CV, 1'b1, 100);
		st(8'h60, 8'h20);
		waitFor(SIG_HIZ, 1'b1, 60);
		cyc(2);
		st(8'h78, 8'h58);
		chk("irq", 8'h01, 8'(interruptOutLow));
		ld(16'h0f3c);
		cyc(8);
		st(8'h38, 8'h28);
		stall <= 1'b1;
		wr(8'h7f);
		ld(16'h09c4);
		cyc(2);
		st(8'h70, 8'h00);
		chk("chargeOn", 8'h00, 8'(chargeOn));
		wr(8'h3f);
		cyc(5);
		st(8'h60, 8'h60);
		chk("tenth", 8'h01, 8'(precondTenth));
		cyc(25);
		st(8'h70, 8'h00);
		stall <= 1'b0;
		@(posedge sys_clk) inMv <= 16'h0bb8;
		cyc(6);
		st(8'h63, 8'h01);
		@(posedge sys_clk) inMv <= 16'h0ed8;
		cyc(6);
		st(8'h62, 8'h02);
		@(posedge sys_clk) inMv <= 16'h1194;
		cyc(6);
		st(8'h60, 8'h60);
		@(posedge sys_clk) inMv <= 16'h1b58;
		cyc(6);
		st(8'h62, 8'h00);
		@(posedge sys_clk) inMv <= 16'h189c;
		cyc(6);
		st(8'h62, 8'h02);
		@(posedge sys_clk) inMv <= 16'h1388;
		cyc(6);
		st(8'h20, 8'h20);
		@(posedge sys_clk) batteryPresent <= 1'b0;
		cyc(6);
		st(8'h60, 8'h00);
		@(posedge sys_clk) batteryPresent <= 1'b1;
		stall <= 1'b1;
		wr(8'h7f);
		ld(16'h0dac);
		wr(8'h3f);
		waitFor(SIG_ON, 1'b1, 10);
		waitFor(SIG_HIZ, 1'b1, 90);
		st(8'h10, 8'h10);
		waitFor(SIG_ON, 1'b1, 20);
		stall <= 1'b0;
		repeat (8) begin
			seed = lfsr(seed);
			@(posedge sys_clk);
			supplyTypeSelect <= seed[0];
			currentLevelSelect <= seed[1];
			systemRailSag <= seed[2];
			cyc(5);
			chk("acMode", 8'(seed[0]), 8'(acMode));
			chk("usb", 8'(!seed[0] && seed[1]), 8'(usbHighLimit));
			chk("div", 8'(seed[0] && !seed[1]), 8'(acDivideFive));
			chk("sag", 8'(seed[2]), 8'(sagReduce));
			st(8'h04, {5'h00, seed[0], 2'h0});
		end
		// both event enables off: a disconnect and a state change must raise nothing
		wr(8'h36);
		rd(ADDR_STATUS, d);
		@(posedge sys_clk) inMv <= 16'h0bb8;
		cyc(6);
		st(8'h0b, 8'h00);
		chk("irq", 8'h01, 8'(interruptOutLow));
		finishTest();
	end

	initial begin
		repeat (20000) @(posedge sys_clk);
		numErrors++;
		finishTest();
	end
endmodule
